// ### rtl/dram_bank_map_decode.sv
// Purpose: DRAM bank placement, row/column strobe and address mux
// Assumes: All inputs synchronous to core_clk
// Notes:   Cycle timing, paging and refresh live in other blocks
`timescale 1ns/1ns
module dram_bank_map_decode
  import dram_map_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           reset_n,
  input  wire logic [7:0]     io_addr,
  input  wire logic           io_wr,
  input  wire logic           io_rd,
  input  wire logic [7:0]     io_wdata,
  output logic      [7:0]     io_rdata,
  output logic                io_claim,
  input  wire logic [7:0]     memory_setup_register,
  input  wire logic [25:2]    cpu_addr,
  input  wire logic           mem_req,
  input  wire logic           page_hit,
  input  wire logic           row_phase,
  input  wire logic           segment_hole,
  input  wire logic           region_hole,
  output logic                dram_select,
  output dram_drive_type      dram_pins
);

  logic [7:0]   index_q;
  logic [7:0]   bank01_config_q;
  logic [7:0]   bank23_config_q;
  bank_cfg_type cfg [4];
  logic [6:0]   sz [4];
  logic [6:0]   st [4];
  logic [1:0]   sh [4];
  logic [2:0]   interleave_select;
  logic [6:0]   a_mb;
  logic [3:0]   sel;
  logic [3:0]   ras;
  logic [3:0]   cas;
  logic [1:0]   dev_size;
  logic [10:1]  col_addr;
  logic [10:1]  row_addr;
  logic         any_ilv;
  logic         four_way;
  logic         pick01;
  logic         pick23;
  logic         open_row;
  logic         addr_bit0_d;
  logic         addr_bit0_q;
  logic [3:0]   row_strobe_n_q;
  logic [3:0]   column_strobe_q;
  logic [10:1]  mem_addr_q;

  // Bounds are compared at eight bits so a full 64 MB top cannot wrap
  function automatic logic not_below(input logic [6:0] a,
                                     input logic [7:0] b);
    return {1'b0, a} >= b;
  endfunction : not_below

  // Index and data port pair; other indexes belong to other blocks
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      index_q <= INDEX_RESET;
    end else if (io_wr && io_addr == INDEX_PORT) begin
      index_q <= io_wdata; // R22
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank01_config_q <= CFG_RESET; // R25
      bank23_config_q <= CFG_RESET; // R25
    end else if (io_wr && io_addr == DATA_PORT) begin
      if (pick01) begin
        bank01_config_q <= io_wdata | CFG_ONES; // R1 R24
      end
      if (pick23) begin
        bank23_config_q <= io_wdata | CFG_ONES; // R2 R24
      end
    end
  end

  // Read data is registered; io_claim marks a read this block answered
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
      io_claim <= 1'b0;
    end else begin
      io_rdata <= 8'h00;
      io_claim <= 1'b0;
      if (io_rd && io_addr == INDEX_PORT) begin
        io_rdata <= index_q;
        io_claim <= 1'b1;
      end else if (io_rd && io_addr == DATA_PORT) begin
        if (pick01) begin
          io_rdata <= bank01_config_q; // R1
          io_claim <= 1'b1;
        end else if (pick23) begin
          io_rdata <= bank23_config_q; // R2
          io_claim <= 1'b1;
        end
      end
    end
  end

  assign interleave_select = memory_setup_register[ILV_MSB:ILV_LSB]; // R4
  assign cfg[0] = bank_cfg_type'(bank01_config_q[3:0]); // R1
  assign cfg[1] = bank_cfg_type'(bank01_config_q[7:4]); // R1
  assign cfg[2] = bank_cfg_type'(bank23_config_q[3:0]); // R2
  assign cfg[3] = bank_cfg_type'(bank23_config_q[7:4]); // R2
  assign a_mb   = {1'b0, cpu_addr[25:MB_LSB]};
  assign pick01 = index_q == BANK01_IDX;
  assign pick23 = index_q == BANK23_IDX;
  assign open_row = row_phase && !page_hit; // R18

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      sz[b] = size_mb(cfg[b]); // R12
    end
  end

  // Start of each bank and span shift: 0 alone, 1 paired, 2 four-way
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      st[b] = 7'h00;
      sh[b] = 2'h0;
    end
    case (interleave_select) // R3 R11
      ILV_NONE: begin
        st[1] = sz[0];
        st[2] = sz[0] + sz[1];
        st[3] = sz[0] + sz[1] + sz[2];
      end
      ILV_01: begin
        st[2] = sz[0] << 1;
        st[3] = (sz[0] << 1) + sz[2];
        sh[0] = 2'h1;
        sh[1] = 2'h1;
      end
      ILV_03: begin
        st[1] = sz[0] << 1;
        st[2] = (sz[0] << 1) + sz[1];
        sh[0] = 2'h1;
        sh[3] = 2'h1;
      end
      ILV_12: begin
        st[0] = sz[2] << 1;
        st[3] = sz[0] + (sz[2] << 1);
        sh[1] = 2'h1;
        sh[2] = 2'h1;
      end
      ILV_23: begin
        st[0] = sz[2] << 1;
        st[1] = sz[0] + (sz[2] << 1);
        sh[2] = 2'h1;
        sh[3] = 2'h1;
      end
      ILV_01_23: begin
        st[2] = sz[0] << 1;
        st[3] = sz[0] << 1;
        for (int b = 0; b < 4; b++) sh[b] = 2'h1;
      end
      ILV_03_12: begin
        st[1] = sz[0] << 1;
        st[2] = sz[0] << 1;
        for (int b = 0; b < 4; b++) sh[b] = 2'h1;
      end
      ILV_FOUR: begin
        for (int b = 0; b < 4; b++) sh[b] = 2'h2;
      end
      default: begin
        for (int b = 0; b < 4; b++) sh[b] = 2'h0;
      end
    endcase
  end

  // Unlike interleave partners give undefined placement, as allowed
  always_comb begin
    logic [7:0] lim;
    logic [7:0] mid;
    logic [6:0] span;
    logic       hit;
    logic       upper;
    lim  = 8'h00;
    mid  = 8'h00;
    span = 7'h00;
    hit  = 1'b0;
    upper = 1'b0;
    sel  = 4'h0;
    ras  = 4'h0;
    cas  = 4'h0;
    dev_size = SIZE_NONE;
    any_ilv  = 1'b0;
    four_way = 1'b0;
    for (int b = 3; b >= 0; b--) begin
      span  = sz[b] << sh[b]; // R5
      lim   = {1'b0, st[b]} + {1'b0, span};
      mid   = {1'b0, st[b]} + {2'b00, span[6:1]};
      hit   = (sz[b] != 7'h00) && not_below(a_mb, {1'b0, st[b]})
              && !not_below(a_mb, lim); // R13 R14
      if (sh[b] == 2'h2 && (b[1] != cpu_addr[14])) begin
        hit = 1'b0; // R9 R10
      end
      if (!mem_req || segment_hole || region_hole) begin
        hit = 1'b0; // R6
      end
      upper = not_below(a_mb, mid); // R15 R20
      sel[b] = hit;
      if (hit) begin
        dev_size = cfg[b].size;
        any_ilv  = sh[b] != 2'h0;
        four_way = sh[b] == 2'h2;
        if (cfg[b].double_sided) begin
          ras[{b[1], upper}] = 1'b1; // R15 R21
        end else begin
          ras[b] = 1'b1; // R13 R14
        end
        if (sh[b] == 2'h0 || b[0] == cpu_addr[2]) begin
          cas[b] = 1'b1; // R8 R16 R17
        end
      end
    end
  end

  // Column address; bit 0 copies follow A3 so bursts move only low bits
  always_comb begin
    col_addr       = 10'h000;
    col_addr[8:2]  = cpu_addr[10:4]; // R23
    col_addr[1]    = any_ilv ? cpu_addr[11] : cpu_addr[2]; // R19 R23
    if (dev_size == SIZE_4M) begin
      col_addr[10] = any_ilv ? cpu_addr[13] : cpu_addr[12]; // R23
    end
    if (dev_size == SIZE_1M || dev_size == SIZE_4M) begin
      col_addr[9]  = any_ilv ? cpu_addr[12] : cpu_addr[11]; // R23
    end
  end

  always_comb begin
    row_addr       = 10'h000;
    row_addr[8:4]  = cpu_addr[19:15]; // R23
    row_addr[3]    = cpu_addr[14];
    row_addr[2]    = cpu_addr[13];
    row_addr[1]    = cpu_addr[20];
    if (dev_size == SIZE_4M) begin
      row_addr[10] = cpu_addr[23];
    end
    if (dev_size == SIZE_1M || dev_size == SIZE_4M) begin
      row_addr[9]  = cpu_addr[21];
    end
    if (four_way) begin
      case (dev_size)
        SIZE_256K: row_addr[3] = cpu_addr[21];
        SIZE_1M:   row_addr[3] = cpu_addr[23];
        SIZE_4M:   row_addr[3] = cpu_addr[25];
        default:   row_addr[3] = cpu_addr[14];
      endcase
    end
    if (any_ilv && dev_size == SIZE_4M) begin
      row_addr[2]  = cpu_addr[24];
    end
    if (!any_ilv && dev_size == SIZE_256K) begin
      row_addr[1]  = cpu_addr[11];
    end
  end

  // Registered strobes keep glitches from the wide compares off the pins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      row_strobe_n_q  <= RAS_IDLE;
      column_strobe_q <= 4'h0;
      dram_select     <= 1'b0;
    end else begin
      row_strobe_n_q  <= ~ras; // R13 R14
      column_strobe_q <= cas; // R16
      dram_select     <= |sel;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr_q <= 10'h000;
    end else if (open_row) begin
      mem_addr_q <= row_addr; // R18
    end else begin
      mem_addr_q <= col_addr; // R18
    end
  end

  // Row phase parks bit 0 on A12; column phase lets it follow A3
  assign addr_bit0_d = open_row ? cpu_addr[12] : cpu_addr[3];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_bit0_q <= 1'b0;
    end else begin
      addr_bit0_q <= addr_bit0_d; // R19
    end
  end

  // One flop feeds both bit-0 copies; board timing tells them apart
  assign dram_pins = '{row_strobe_n:         row_strobe_n_q,
                       column_strobe:        column_strobe_q,
                       mem_addr_bus:         mem_addr_q,
                       addr_bit0_even_banks: addr_bit0_q, // R19
                       addr_bit0_odd_banks:  addr_bit0_q};

endmodule : dram_bank_map_decode

// ### rtl/dram_map_pkg.sv
// Purpose: Constants, types and helpers for the DRAM bank map decoder
// Assumes: One 20 MHz core clock, index/data configuration ports
// Notes:   Sizes and bank starts are counted in 1 MB units
//
// Summary of operation
// (R1) Index 02h: bank0 low nibble, bank1 high nibble
// (R2) Index 03h: banks 2/3; size 00 empty, 11 4M
// (R3) Decode eight interleave pairing codes
// (R4) Interleave code from setup register bits 7-5
// (R5) Map starts at zero, contiguous, pairs share range
// (R6) Segment and region holes excluded from decode
// (R7) Software interleaves only identical banks
// (R8) Two-way: A2 picks even or odd bank
// (R9) Four-way: A14,A2 pick bank 0..3
// (R10) Burst touches only one pair of banks
// (R11) Bank starts from interleave code and sizes
// (R12) Bank size table: 0,1,2,4,8,16 MB
// (R13) Non-interleaved: strobe the one containing bank
// (R14) Interleaved: strobe both pair banks together
// (R15) Double-sided: lower half even, upper odd strobe
// (R16) Column strobe when address in bank range
// (R17) Interleaved column strobe follows A2
// (R18) Row then column, column only on hits
// (R19) Burst: only bit 1 and bit-0 copies move
// (R20) Double-sided sides contiguous, lower side first
// (R21) Never both shared row strobes of a pair
// (R22) Software uses index port then data port
// (R23) Column and row address bit mapping table
// (R24) Bits 7 and 3 read one, writes ignored
// (R25) Reset reports every bank empty
package dram_map_pkg;
  localparam logic [7:0] INDEX_PORT  = 8'hec;
  localparam logic [7:0] DATA_PORT   = 8'hed;
  localparam logic [7:0] BANK01_IDX  = 8'h02;
  localparam logic [7:0] BANK23_IDX  = 8'h03;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET   = 8'h88;
  localparam logic [7:0] CFG_ONES    = 8'h88;
  localparam logic [3:0] RAS_IDLE    = 4'hf;
  localparam int         ILV_MSB     = 7;
  localparam int         ILV_LSB     = 5;
  localparam int         MB_LSB      = 20;

  localparam logic [1:0] SIZE_NONE = 2'h0;
  localparam logic [1:0] SIZE_256K = 2'h1;
  localparam logic [1:0] SIZE_1M   = 2'h2;
  localparam logic [1:0] SIZE_4M   = 2'h3;

  localparam logic [2:0] ILV_NONE  = 3'h0;
  localparam logic [2:0] ILV_01    = 3'h1;
  localparam logic [2:0] ILV_03    = 3'h2;
  localparam logic [2:0] ILV_12    = 3'h3;
  localparam logic [2:0] ILV_23    = 3'h4;
  localparam logic [2:0] ILV_01_23 = 3'h5;
  localparam logic [2:0] ILV_03_12 = 3'h6;
  localparam logic [2:0] ILV_FOUR  = 3'h7;

  typedef struct packed {
    logic       fixed_one;
    logic [1:0] size;
    logic       double_sided;
  } bank_cfg_type;

  typedef struct packed {
    logic [3:0]  row_strobe_n;
    logic [3:0]  column_strobe;
    logic [10:1] mem_addr_bus;
    logic        addr_bit0_even_banks;
    logic        addr_bit0_odd_banks;
  } dram_drive_type;

  function automatic logic [6:0] size_mb(input bank_cfg_type c);
    logic [6:0] s;
    s = 7'h00;
    case (c.size)
      SIZE_256K: s = c.double_sided ? 7'h02 : 7'h01;
      SIZE_1M:   s = c.double_sided ? 7'h08 : 7'h04;
      SIZE_4M:   s = 7'h10;
      default:   s = 7'h00;
    endcase
    return s;
  endfunction : size_mb
endpackage : dram_map_pkg

// ### test/dram_map_checker.sv
// Purpose: Port assertions for the DRAM bank map decoder
// Assumes: Decode outputs land one edge after their inputs
// Notes:   Holes and idle cycles must leave every strobe off
`timescale 1ns/1ns
module dram_map_checker
  import dram_map_pkg::*;
(
  input wire logic           core_clk,
  input wire logic           reset_n,
  input wire logic [7:0]     io_addr,
  input wire logic           io_rd,
  input wire logic [7:0]     io_rdata,
  input wire logic           io_claim,
  input wire logic [7:0]     memory_setup_register,
  input wire logic [25:2]    cpu_addr,
  input wire logic           mem_req,
  input wire logic           page_hit,
  input wire logic           row_phase,
  input wire logic           segment_hole,
  input wire logic           region_hole,
  input wire logic           dram_select,
  input wire dram_drive_type dram_pins
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic       hole;
  logic       col_ph;
  logic [2:0] ilv;
  logic [3:0] rs;
  assign hole = segment_hole || region_hole;
  assign col_ph = mem_req && (!row_phase || page_hit) && !hole;
  assign ilv = memory_setup_register[7:5];
  assign rs = dram_pins.row_strobe_n;
  property p_idle;
    !mem_req |=> rs == 4'hf && dram_pins.column_strobe == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe without request");
  property p_hole;
    hole |=> rs == 4'hf && dram_pins.column_strobe == 4'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("strobe in hole");
  property p_sel;
    dram_select == (rs != 4'hf);
  endproperty
  a_sel: assert property (p_sel) else $error("select mismatch");
  property p_ones;
    io_claim && $past(io_addr) == DATA_PORT |-> io_rdata[7] && io_rdata[3];
  endproperty
  a_ones: assert property (p_ones) else $error("fixed bits not one");
  property p_quiet;
    !io_rd |=> !io_claim && io_rdata == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data unasked");
  property p_col;
    col_ph |=> dram_pins.mem_addr_bus[8:2] == $past(cpu_addr[10:4])
      && dram_pins.addr_bit0_even_banks == $past(cpu_addr[3])
      && dram_pins.addr_bit0_odd_banks == $past(cpu_addr[3]);
  endproperty
  a_col: assert property (p_col) else $error("column address wrong");
  property p_row;
    mem_req && row_phase && !page_hit && !hole
      |=> dram_pins.mem_addr_bus[8:4] == $past(cpu_addr[19:15]);
  endproperty
  a_row: assert property (p_row) else $error("row address wrong");
  property p_four;
    mem_req && ilv == 3'h7 |=> rs[1:0] == 2'b11 || rs[3:2] == 2'b11;
  endproperty
  a_four: assert property (p_four) else $error("four-way overreach");
  property p_two;
    mem_req && ilv == 3'h1 && !cpu_addr[2] |=> !dram_pins.column_strobe[1];
  endproperty
  a_two: assert property (p_two) else $error("odd column on A2 low");
  c_four: cover property (mem_req && ilv == 3'h7 ##1 dram_select);
  c_claim: cover property (io_claim);
  c_dbl: cover property (rs == 4'hd);
endmodule : dram_map_checker
bind dram_bank_map_decode dram_map_checker chk_u (.core_clk(core_clk),
  .reset_n(reset_n), .io_addr(io_addr), .io_rd(io_rd),
  .io_rdata(io_rdata),
  .io_claim(io_claim), .memory_setup_register(memory_setup_register),
  .cpu_addr(cpu_addr), .mem_req(mem_req), .page_hit(page_hit),
  .row_phase(row_phase), .segment_hole(segment_hole),
  .region_hole(region_hole), .dram_select(dram_select),
  .dram_pins(dram_pins));

// ### test/dram_bank_model.sv
// Purpose: DRAM bank array seen from the strobe pins
// Assumes: Row strobes active low
// Notes:   Remembers which banks opened since the last clear
`timescale 1ns/1ns
module dram_bank_model
  import dram_map_pkg::*;
(
  input wire logic           core_clk,
  input wire logic           clr,
  input wire dram_drive_type pins,
  output logic [3:0]         ras_seen
);
  // Sticky record so a whole burst can be judged at its end
  always_ff @(posedge core_clk) begin
    if (clr) begin
      ras_seen <= 4'h0;
    end else begin
      ras_seen <= ras_seen | ~pins.row_strobe_n;
    end
  end
endmodule : dram_bank_model

// ### test/tb_dram_bank_map_decode.sv
// Purpose: Scenario bench for the DRAM bank map decoder
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes:   Expectations use 1 MB banks except in t_flat, t_double and t_mux
`timescale 1ns/1ns
module tb_dram_bank_map_decode;
  import dram_map_pkg::*;
  logic core_clk = 0, reset_n = 0, io_wr = 0, io_rd = 0, io_claim;
  logic mem_req = 0, page_hit = 0, row_phase = 0, clr = 0, dram_select;
  logic segment_hole = 0, region_hole = 0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata;
  logic [7:0] memory_setup_register = 8'h00;
  logic [25:2] cpu_addr = '0;
  logic [3:0] ras_seen;
  dram_drive_type dram_pins;
  int n_mismatch = 0, cmp_count = 0;
  dram_bank_map_decode dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_claim(io_claim),
    .memory_setup_register(memory_setup_register), .cpu_addr(cpu_addr),
    .mem_req(mem_req), .page_hit(page_hit), .row_phase(row_phase),
    .segment_hole(segment_hole), .region_hole(region_hole),
    .dram_select(dram_select), .dram_pins(dram_pins));
  dram_bank_model mdl_u (.core_clk(core_clk), .clr(clr), .pins(dram_pins),
    .ras_seen(ras_seen));
  always #25 core_clk = ~core_clk;
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_wr <= w;
    io_rd <= !w;
    io_addr <= a;
    io_wdata <= d;
    @(posedge core_clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask : io
  task automatic cfg(input logic [7:0] i, input logic [7:0] v);
    io(1'b1, INDEX_PORT, i);
    io(1'b1, DATA_PORT, v);
  endtask : cfg
  task automatic rd(input logic [7:0] i, input logic [8:0] e);
    io(1'b1, INDEX_PORT, i);
    io(1'b0, DATA_PORT, 8'h00);
    chk({7'h0, io_claim, io_rdata}, {7'h0, e});
  endtask : rd
  task automatic go(input logic [25:0] a, input logic rp, input logic ph);
    @(posedge core_clk);
    cpu_addr <= a[25:2];
    mem_req <= 1'b1;
    row_phase <= rp;
    page_hit <= ph;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : go
  task automatic dec(input logic [25:0] a, input logic [3:0] r,
                     input logic [3:0] c);
    go(a, 1'b1, 1'b0);
    chk({7'h0, dram_select, c, r}, {7'h0, r != 4'hf, c, r});
  endtask : dec
  task automatic t_regs();
    rd(BANK01_IDX, 9'h188);
    rd(BANK23_IDX, 9'h188);
    rd(8'h05, 9'h000);
    cfg(BANK01_IDX, 8'h4a);
    rd(BANK01_IDX, 9'h1ca);
    cfg(BANK23_IDX, 8'h13);
    rd(BANK23_IDX, 9'h19b);
    io(1'b0, INDEX_PORT, 8'h00);
    chk({7'h0, io_claim, io_rdata}, 16'h0103);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_flat();
    cfg(BANK23_IDX, 8'h88);
    @(posedge core_clk) memory_setup_register <= 8'h1f;
    dec(26'h000000, 4'he, 4'h1);
    dec(26'h100000, 4'hd, 4'h2);
    dec(26'h4ffffc, 4'hd, 4'h2);
    dec(26'h500000, 4'hf, 4'h0);
    @(posedge core_clk) segment_hole <= 1'b1;
    dec(26'h000000, 4'hf, 4'h0);
    @(posedge core_clk);
    segment_hole <= 1'b0;
    region_hole <= 1'b1;
    dec(26'h100000, 4'hf, 4'h0);
    @(posedge core_clk) region_hole <= 1'b0;
    $display("t_flat done");
  endtask : t_flat
  task automatic t_modes();
    logic [3:0] r [8] = '{4'he, 4'hc, 4'h6, 4'h9, 4'h3, 4'hc, 4'h6, 4'hc};
    logic [3:0] c [8] = '{4'h1, 4'h1, 4'h1, 4'h4, 4'h4, 4'h1, 4'h1, 4'h1};
    cfg(BANK01_IDX, 8'haa);
    cfg(BANK23_IDX, 8'haa);
    for (int m = 0; m < 8; m++) begin
      @(posedge core_clk) memory_setup_register <= {m[2:0], 5'h1f};
      dec(26'h000000, r[m], c[m]);
    end
    @(posedge core_clk) memory_setup_register <= 8'h20;
    dec(26'h1ffffc, 4'hc, 4'h2);
    dec(26'h200000, 4'hb, 4'h4);
    @(posedge core_clk);
    memory_setup_register <= 8'he0;
    clr <= 1'b1;
    dec(26'h004004, 4'h3, 4'h8);
    @(posedge core_clk) clr <= 1'b0;
    dec(26'h004000, 4'h3, 4'h4);
    dec(26'h004004, 4'h3, 4'h8);
    chk({12'h0, ras_seen}, 16'h000c);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_double();
    cfg(BANK01_IDX, 8'h8b);
    cfg(BANK23_IDX, 8'h88);
    @(posedge core_clk) memory_setup_register <= 8'h00;
    dec(26'h0ffffc, 4'he, 4'h1);
    dec(26'h100000, 4'hd, 4'h1);
    dec(26'h200000, 4'hf, 4'h0);
    $display("t_double done");
  endtask : t_double
  task automatic t_mux();
    logic [25:0] a;
    a = 26'h00a85c;
    cfg(BANK01_IDX, 8'h8a);
    go(a, 1'b1, 1'b0);
    chk({6'h00, dram_pins.mem_addr_bus}, {8'h00, a[19:13], a[11]});
    go(a, 1'b0, 1'b0);
    chk({4'h0, dram_pins.mem_addr_bus, dram_pins.addr_bit0_even_banks,
         dram_pins.addr_bit0_odd_banks},
        {6'h00, a[10:4], a[2], a[3], a[3]});
    go(a, 1'b1, 1'b1);
    chk({6'h00, dram_pins.mem_addr_bus}, {8'h00, a[10:4], a[2]});
    cfg(BANK01_IDX, 8'haa);
    @(posedge core_clk) memory_setup_register <= 8'h20;
    go(a, 1'b0, 1'b0);
    chk({6'h00, dram_pins.mem_addr_bus}, {8'h00, a[10:4], a[11]});
    cfg(BANK01_IDX, 8'hee);
    a = 26'h1a5a85c;
    go(a, 1'b1, 1'b0);
    chk({6'h00, dram_pins.mem_addr_bus},
        {6'h00, a[23], a[21], a[19:14], a[24], a[20]});
    go(a, 1'b0, 1'b0);
    chk({6'h00, dram_pins.mem_addr_bus},
        {6'h00, a[13:12], a[10:4], a[11]});
    @(posedge core_clk) mem_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk({12'h0, dram_pins.row_strobe_n}, 16'h000f);
    $display("t_mux done");
  endtask : t_mux
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_flat();
    t_modes();
    t_double();
    t_mux();
    test_done();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #1000000;
    n_mismatch++;
    test_done();
  end
endmodule : tb_dram_bank_map_decode
